// ===== design/poior_pkg.sv
// Constants for the port override and general I/O register block.
// Assumes an 8-bit register port on the system clock and 8-bit ports.
// Behaviour
// - Serial 0 transmitter on forces pin 1 output
// - Serial 0 receiver on forces pin 0 input
// - Forced-input pull-up still follows latch bit
// - Pins 7-4 carry compare outputs when enabled
// - Pins 3,1 transmit overrides; pin 2 receive override
// - Pull-up disable bit kills every pull-up
// - Latch and direction registers reset to zero
// - Pin sample register returns pin levels after two sync stages
package poior_pkg;
	// Sizes
	localparam int unsigned PORT_W = 8;
	localparam int unsigned BANKS = 3;
	localparam int unsigned PADS = 32;
	// Register map: bank n sits at n * stride plus field offset
	localparam logic [7:0] BANK_STRIDE = 8'h03;
	localparam logic [7:0] OFS_PIN = 8'h00;
	localparam logic [7:0] OFS_DIR = 8'h01;
	localparam logic [7:0] OFS_LATCH = 8'h02;
	localparam logic [7:0] ADDR_CTRL = 8'h35;
	// Reset values and idle read data
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	// Core control: bits 3 and 2 are read-only zero
	localparam logic [7:0] CTRL_WR_MASK = 8'hF3;
	localparam int unsigned CTRL_DBG_BIT = 7;
	localparam int unsigned CTRL_PUD_BIT = 4;
	localparam int unsigned CTRL_VECTOR_TABLE_SELECT_BIT = 1;
	localparam int unsigned CTRL_VECTOR_CHANGE_UNLOCK_BIT = 0;
	// Override port placement in the pad vector and its pins
	localparam int unsigned OVR_BASE = 24;
	localparam int unsigned PIN_RX0 = 0;
	localparam int unsigned PIN_TX0 = 1;
	localparam int unsigned PIN_RX1 = 2;
	localparam int unsigned PIN_TX1 = 3;
	localparam int unsigned PIN_CMP_LO = 4;
	localparam int unsigned PIN_CAP = 6;
	localparam int unsigned PIN_XCK = 4;
endpackage

// ===== design/poior_pad_slice.sv
// One pad's control mux: register-derived value or peripheral override.
// Assumes all inputs come from logic on the system clock.
`timescale 1ns/1ps
`default_nettype none
module poior_pad_slice (
	// Register-derived controls
	input wire logic dir_i,
	input wire logic latch_i,
	input wire logic pud_i,
	// Peripheral overrides
	input wire logic pullup_override_enable_i,
	input wire logic pullup_override_value_i,
	input wire logic direction_override_enable_i,
	input wire logic direction_override_value_i,
	input wire logic output_value_override_enable_i,
	input wire logic output_value_override_value_i,
	input wire logic input_enable_override_enable_i,
	input wire logic input_enable_override_value_i,
	// Resulting pad controls
	output logic pullup_o,
	output logic oe_o,
	output logic out_o,
	output logic in_en_o
);
	// Pull-up only for an input with latch high, unless disabled globally
	assign pullup_o = pullup_override_enable_i ? pullup_override_value_i
		: (~dir_i & latch_i & ~pud_i);
	// Direction
	assign oe_o = direction_override_enable_i ? direction_override_value_i : dir_i;
	// Output value
	assign out_o = output_value_override_enable_i ? output_value_override_value_i : latch_i;
	// Input path stays on; no sleep gating in this block
	assign in_en_o = input_enable_override_enable_i ? input_enable_override_value_i : 1'b1;
endmodule
`default_nettype wire

// ===== design/poior_top.sv
// Three general ports with registers, plus the override port pad logic.
// Assumes a single-cycle register master and raw asynchronous pad inputs.
`timescale 1ns/1ps
`default_nettype none
module poior_top (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// General port pads
	input wire logic [7:0] bank_a_pad_in_i,
	input wire logic [7:0] bank_b_pad_in_i,
	input wire logic [7:0] bank_c_pad_in_i,
	output logic [7:0] bank_a_pad_out_o,
	output logic [7:0] bank_a_pad_oe_o,
	output logic [7:0] bank_a_pullup_o,
	output logic [7:0] bank_b_pad_out_o,
	output logic [7:0] bank_b_pad_oe_o,
	output logic [7:0] bank_b_pullup_o,
	output logic [7:0] bank_c_pad_out_o,
	output logic [7:0] bank_c_pad_oe_o,
	output logic [7:0] bank_c_pullup_o,
	// Override port: its own registers live elsewhere
	input wire logic [7:0] ovr_latch_i,
	input wire logic [7:0] ovr_direction_i,
	input wire logic [7:0] ovr_pad_in_i,
	output logic [7:0] ovr_pad_out_o,
	output logic [7:0] ovr_pad_oe_o,
	output logic [7:0] ovr_pullup_o,
	// Serial channel controls and transmit data
	input wire logic serial0_transmitter_on_i,
	input wire logic serial0_receiver_on_i,
	input wire logic serial1_transmitter_on_i,
	input wire logic serial1_receiver_on_i,
	input wire logic serial0_transmit_line_i,
	input wire logic serial1_transmit_line_i,
	// Timer compare outputs and their enables
	input wire logic timer1_compare_b_en_i,
	input wire logic timer1_compare_b_out_i,
	input wire logic timer1_compare_a_en_i,
	input wire logic timer1_compare_a_out_i,
	input wire logic timer2_compare_b_en_i,
	input wire logic timer2_compare_b_out_i,
	input wire logic timer2_compare_a_en_i,
	input wire logic timer2_compare_a_out_i,
	// Input-path enables from interrupt logic
	input wire logic pin_change_group3_enable_i,
	input wire logic [7:0] pin_change_mask_i,
	input wire logic external_irq_0_en_i,
	input wire logic external_irq_1_en_i,
	// Sampled pins handed to peripherals
	output logic serial0_receive_line_o,
	output logic serial1_receive_line_o,
	output logic timer1_capture_input_o,
	output logic timer3_count_input_o,
	output logic serial1_external_clock_o,
	output logic external_irq_0_o,
	output logic external_irq_1_o,
	output logic [7:0] pin_change_source_o,
	// Core control bits
	output logic debug_port_disable_o,
	output logic global_pullup_disable_o,
	output logic vector_table_select_o,
	output logic vector_change_unlock_o
);
	// Whole state of the block
	typedef struct packed {
		logic [poior_pkg::BANKS-1:0][poior_pkg::PORT_W-1:0] latch; // Output latches
		logic [poior_pkg::BANKS-1:0][poior_pkg::PORT_W-1:0] dir; // Directions
		logic [poior_pkg::PORT_W-1:0] ctrl; // Core control
		logic [poior_pkg::PADS-1:0] sync1; // First sync stage, read by sync2 only
		logic [poior_pkg::PADS-1:0] sync2; // Second sync stage
		logic [poior_pkg::PADS-1:0] din; // Sampled, input-enable gated levels
		logic [poior_pkg::PADS-1:0] pad_out; // Registered pad drive
		logic [poior_pkg::PADS-1:0] pad_oe; // Registered pad enable
		logic [poior_pkg::PADS-1:0] pad_pu; // Registered pull-up control
		logic [poior_pkg::PORT_W-1:0] rdata; // Read answer, one cycle
	} poior_state_t;

	poior_state_t state_r;
	poior_state_t state_nxt;

	// Per-pad override and derived signals
	logic [poior_pkg::PADS-1:0] pad_in;
	logic [poior_pkg::PADS-1:0] pad_dir;
	logic [poior_pkg::PADS-1:0] pad_latch;
	logic [poior_pkg::PADS-1:0] pullup_override_enable;
	logic [poior_pkg::PADS-1:0] pullup_override_value;
	logic [poior_pkg::PADS-1:0] direction_override_enable;
	logic [poior_pkg::PADS-1:0] direction_override_value;
	logic [poior_pkg::PADS-1:0] output_value_override_enable;
	logic [poior_pkg::PADS-1:0] output_value_override_value;
	logic [poior_pkg::PADS-1:0] input_enable_override_enable;
	logic [poior_pkg::PADS-1:0] input_enable_override_value;
	logic [poior_pkg::PADS-1:0] mux_pu;
	logic [poior_pkg::PADS-1:0] mux_oe;
	logic [poior_pkg::PADS-1:0] mux_out;
	logic [poior_pkg::PADS-1:0] mux_ie;
	logic global_pullup_disable;
	// Compare enable seen by the pin 4 check; a plain copy keeps the property short
	logic timer1_compare_b_enable_hold;
	assign timer1_compare_b_enable_hold = timer1_compare_b_en_i;

	assign pad_in = {ovr_pad_in_i, bank_c_pad_in_i, bank_b_pad_in_i, bank_a_pad_in_i};
	assign pad_dir = {ovr_direction_i, state_r.dir};
	assign pad_latch = {ovr_latch_i, state_r.latch};
	assign global_pullup_disable = state_r.ctrl[poior_pkg::CTRL_PUD_BIT];

	// Override table; general banks carry none
	always_comb begin
		pullup_override_enable = '0;
		pullup_override_value = '0;
		direction_override_enable = '0;
		direction_override_value = '0;
		output_value_override_enable = '0;
		output_value_override_value = '0;
		input_enable_override_enable = '0;
		input_enable_override_value = '0;
		// Compare pins: only the output value is overridden
		output_value_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_CMP_LO +: 4] = {timer2_compare_a_en_i,
			timer2_compare_b_en_i, timer1_compare_a_en_i, timer1_compare_b_en_i};
		output_value_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_CMP_LO +: 4] = {timer2_compare_a_out_i,
			timer2_compare_b_out_i, timer1_compare_a_out_i, timer1_compare_b_out_i};
		// Transmit pins: no pull-up, output, transmit data
		pullup_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX0] = serial0_transmitter_on_i;
		direction_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX0] = serial0_transmitter_on_i;
		direction_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_TX0] = 1'b1;
		output_value_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX0] = serial0_transmitter_on_i;
		output_value_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_TX0] = serial0_transmit_line_i;
		pullup_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = serial1_transmitter_on_i;
		direction_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = serial1_transmitter_on_i;
		direction_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = 1'b1;
		output_value_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = serial1_transmitter_on_i;
		output_value_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = serial1_transmit_line_i;
		// Receive pins: input, pull-up still from the latch bit
		pullup_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX0] = serial0_receiver_on_i;
		pullup_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_RX0] = ovr_latch_i[poior_pkg::PIN_RX0] & ~global_pullup_disable;
		direction_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX0] = serial0_receiver_on_i;
		pullup_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1] = serial1_receiver_on_i;
		pullup_override_value[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1] = ovr_latch_i[poior_pkg::PIN_RX1] & ~global_pullup_disable;
		direction_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1] = serial1_receiver_on_i;
		// Input path held on for pin change and external interrupt use
		input_enable_override_enable[poior_pkg::OVR_BASE +: poior_pkg::PORT_W] = pin_change_mask_i
			& {poior_pkg::PORT_W{pin_change_group3_enable_i}};
		input_enable_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1] = input_enable_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1]
			| external_irq_0_en_i;
		input_enable_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1] = input_enable_override_enable[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1]
			| external_irq_1_en_i;
		input_enable_override_value[poior_pkg::OVR_BASE +: poior_pkg::PORT_W] = '1;
	end

	// One mux slice per pad
	genvar g;
	generate
		for (g = 0; g < poior_pkg::PADS; g++) begin : g_pad
			poior_pad_slice u_slice (
				.dir_i(pad_dir[g]),
				.latch_i(pad_latch[g]),
				.pud_i(global_pullup_disable),
				.pullup_override_enable_i(pullup_override_enable[g]),
				.pullup_override_value_i(pullup_override_value[g]),
				.direction_override_enable_i(direction_override_enable[g]),
				.direction_override_value_i(direction_override_value[g]),
				.output_value_override_enable_i(output_value_override_enable[g]),
				.output_value_override_value_i(output_value_override_value[g]),
				.input_enable_override_enable_i(input_enable_override_enable[g]),
				.input_enable_override_value_i(input_enable_override_value[g]),
				.pullup_o(mux_pu[g]),
				.oe_o(mux_oe[g]),
				.out_o(mux_out[g]),
				.in_en_o(mux_ie[g])
			);
		end
	endgenerate

	// Next state: sync, pad registers, register port
	always_comb begin
		state_nxt = state_r;
		// Pads pass two stages before anything looks at them
		state_nxt.sync1 = pad_in;
		state_nxt.sync2 = state_r.sync1;
		state_nxt.din = state_r.sync2 & mux_ie;
		// Registered pad controls cost one cycle of latency
		state_nxt.pad_out = mux_out;
		state_nxt.pad_oe = mux_oe;
		state_nxt.pad_pu = mux_pu;
		state_nxt.rdata = poior_pkg::RDATA_IDLE;
		for (int b = 0; b < poior_pkg::BANKS; b++) begin
			// Writes: sample-address write toggles the latch bits set in data
			if (wr_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_PIN) begin
				state_nxt.latch[b] = state_r.latch[b] ^ wdata_i;
			end
			if (wr_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_DIR) begin
				state_nxt.dir[b] = wdata_i;
			end
			if (wr_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_LATCH) begin
				state_nxt.latch[b] = wdata_i;
			end
			// Reads answer in the following cycle only
			if (rd_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_PIN) begin
				state_nxt.rdata = state_r.din[b*poior_pkg::PORT_W +: poior_pkg::PORT_W];
			end
			if (rd_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_DIR) begin
				state_nxt.rdata = state_r.dir[b];
			end
			if (rd_i && addr_i == 8'(b) * poior_pkg::BANK_STRIDE + poior_pkg::OFS_LATCH) begin
				state_nxt.rdata = state_r.latch[b];
			end
		end
		// Core control; read-only bits stay zero
		if (wr_i && addr_i == poior_pkg::ADDR_CTRL) begin
			state_nxt.ctrl = wdata_i & poior_pkg::CTRL_WR_MASK;
		end
		if (rd_i && addr_i == poior_pkg::ADDR_CTRL) begin
			state_nxt.rdata = state_r.ctrl;
		end
	end

	// State register; low enable freezes everything
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= '0;
			state_r.latch <= {poior_pkg::BANKS{poior_pkg::LATCH_RST}};
			state_r.dir <= {poior_pkg::BANKS{poior_pkg::DIR_RST}};
			state_r.ctrl <= poior_pkg::CTRL_RST;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Outputs, all from flip-flops
	assign rdata_o = state_r.rdata;
	assign bank_a_pad_out_o = state_r.pad_out[7:0];
	assign bank_a_pad_oe_o = state_r.pad_oe[7:0];
	assign bank_a_pullup_o = state_r.pad_pu[7:0];
	assign bank_b_pad_out_o = state_r.pad_out[15:8];
	assign bank_b_pad_oe_o = state_r.pad_oe[15:8];
	assign bank_b_pullup_o = state_r.pad_pu[15:8];
	assign bank_c_pad_out_o = state_r.pad_out[23:16];
	assign bank_c_pad_oe_o = state_r.pad_oe[23:16];
	assign bank_c_pullup_o = state_r.pad_pu[23:16];
	assign ovr_pad_out_o = state_r.pad_out[31:24];
	assign ovr_pad_oe_o = state_r.pad_oe[31:24];
	assign ovr_pullup_o = state_r.pad_pu[31:24];
	assign serial0_receive_line_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_RX0];
	assign timer3_count_input_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_RX0];
	assign serial1_receive_line_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1];
	assign external_irq_0_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_RX1];
	assign external_irq_1_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_TX1];
	assign timer1_capture_input_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_CAP];
	assign serial1_external_clock_o = state_r.din[poior_pkg::OVR_BASE + poior_pkg::PIN_XCK];
	assign pin_change_source_o = state_r.din[poior_pkg::OVR_BASE +: poior_pkg::PORT_W];
	assign debug_port_disable_o = state_r.ctrl[poior_pkg::CTRL_DBG_BIT];
	assign global_pullup_disable_o = global_pullup_disable;
	assign vector_table_select_o = state_r.ctrl[poior_pkg::CTRL_VECTOR_TABLE_SELECT_BIT];
	assign vector_change_unlock_o = state_r.ctrl[poior_pkg::CTRL_VECTOR_CHANGE_UNLOCK_BIT];

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_dir_a_write;
		ce_i && wr_i && addr_i == poior_pkg::OFS_DIR;
	endsequence
	sequence s_dir_a_read;
		ce_i && rd_i && addr_i == poior_pkg::OFS_DIR;
	endsequence

	a_tx0_drives_pin: assert property (
		ce_i && serial0_transmitter_on_i |=> ovr_pad_oe_o[poior_pkg::PIN_TX0]
			&& ovr_pad_out_o[poior_pkg::PIN_TX0] == $past(serial0_transmit_line_i))
		else $error("transmit pin 1 not driven");
	a_rx0_forces_input: assert property (
		ce_i && serial0_receiver_on_i |=> !ovr_pad_oe_o[poior_pkg::PIN_RX0])
		else $error("receive pin 0 not input");
	a_rx0_pullup_latch: assert property (
		ce_i && serial0_receiver_on_i |=> ovr_pullup_o[poior_pkg::PIN_RX0]
			== $past(ovr_latch_i[poior_pkg::PIN_RX0] & ~global_pullup_disable))
		else $error("receive pull-up not from latch");
	a_compare_out_pass: assert property (
		ce_i && timer2_compare_a_en_i |=> ovr_pad_out_o[7] == $past(timer2_compare_a_out_i)
			&& ovr_pad_oe_o[7] == $past(ovr_direction_i[7]))
		else $error("compare output not on pin 7");
	a_tx1_pin_override: assert property (
		ce_i && serial1_transmitter_on_i |=> ovr_pad_oe_o[poior_pkg::PIN_TX1]
			&& !ovr_pullup_o[poior_pkg::PIN_TX1]
			&& ovr_pad_out_o[poior_pkg::PIN_TX1] == $past(serial1_transmit_line_i))
		else $error("transmit pin 3 override wrong");
	a_pud_no_pullup: assert property (
		ce_i && global_pullup_disable_o |=> bank_a_pullup_o == 8'h00 && bank_b_pullup_o == 8'h00)
		else $error("pull-up on while disabled");
	a_dir_write_read: assert property (
		s_dir_a_write ##1 s_dir_a_read |=> rdata_o == $past(wdata_i, 2))
		else $error("direction readback wrong");
	a_pin_sample_read: assert property (
		ce_i && rd_i && addr_i == poior_pkg::OFS_PIN |=> rdata_o == $past(state_r.din[7:0]))
		else $error("pin sample read wrong");
	a_dir_no_override: assert property (
		ce_i && !serial0_receiver_on_i |=> ovr_pad_oe_o[poior_pkg::PIN_RX0]
			== $past(ovr_direction_i[poior_pkg::PIN_RX0]))
		else $error("direction register not used");
	// No read strobe means the answer falls back to idle data
	a_rdata_idle: assert property (
		ce_i && !rd_i |=> rdata_o == poior_pkg::RDATA_IDLE)
		else $error("read data not idle");
	// Low enable must hold read data, bank A pad drive and enable, and override pad enable where they were
	a_ce_freeze: assert property (
		!ce_i |=> $stable(rdata_o) && $stable(ovr_pad_oe_o) && $stable(bank_a_pad_oe_o)
			&& $stable(bank_a_pad_out_o))
		else $error("state moved while enable low");
	// Pin 2 receive override: input, pull-up from the latch bit
	a_rx1_forces_input: assert property (
		ce_i && serial1_receiver_on_i |=> !ovr_pad_oe_o[poior_pkg::PIN_RX1]
			&& ovr_pullup_o[poior_pkg::PIN_RX1] == $past(ovr_latch_i[poior_pkg::PIN_RX1] & ~global_pullup_disable))
		else $error("receive pin 2 override wrong");
	// A driving transmit pin never keeps its pull-up
	a_tx0_no_pullup: assert property (
		ce_i && serial0_transmitter_on_i |=> !ovr_pullup_o[poior_pkg::PIN_TX0])
		else $error("transmit pin 1 pull-up on");
	// Lowest compare pin carries its compare output when enabled
	a_compare_b_pin4: assert property (
		ce_i && timer1_compare_b_enable_hold |=> ovr_pad_out_o[poior_pkg::PIN_CMP_LO]
			== $past(timer1_compare_b_out_i))
		else $error("compare output not on pin 4");
	// Compare pins never override the pull-up; registers decide it
	a_compare_no_pullup: assert property (
		ce_i |=> ovr_pullup_o[poior_pkg::PIN_CMP_LO +: 4] == $past(~ovr_direction_i[poior_pkg::PIN_CMP_LO +: 4]
			& ovr_latch_i[poior_pkg::PIN_CMP_LO +: 4] & {4{~global_pullup_disable}}))
		else $error("compare pin pull-up overridden");
	// Global disable also wins over a receive pin's latch bit
	a_rx0_pud_kills: assert property (
		ce_i && serial0_receiver_on_i && global_pullup_disable |=> !ovr_pullup_o[poior_pkg::PIN_RX0])
		else $error("receive pull-up on while disabled");
endmodule
`default_nettype wire

// ===== test/poior_board_model.sv
// Board side of every port: resolves each pad line from the chip and the board.
// Assumes the board source behind a released, unpulled pad always drives a level.
`timescale 1ns/1ps
`default_nettype none
module poior_board_model (
	// Pad drive from the chip
	input wire logic [7:0] out_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pullup_i,
	// Level the board source puts on a released pad
	input wire logic [7:0] ext_i,
	// Resolved pad level seen by the chip
	output logic [7:0] level_o
);
	// Chip drive wins; pull-up beats the weak board source on a released pad
	assign level_o = (oe_i & out_i) | (~oe_i & pullup_i) | (~oe_i & ~pullup_i & ext_i);
endmodule
`default_nettype wire

// ===== test/port_override_and_io_registers_tb_top.sv
// Self-checking bench for the port override and I/O register block.
// Assumes the board model file is compiled first; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module port_override_and_io_registers_tb_top;
	// Clock, reset and register port
	logic clk_sys_i, sys_rst_i, ce_i, wr_i, rd_i;
	logic rd_seen = 1'b0;
	logic [7:0] addr_i, wdata_i, rdata_o, exp_v;
	// Bank pads, board levels and tracked register state
	logic [7:0] pout [3], poe [3], ppu [3], plv [3], ext [3], dir [3], lat [3];
	// Override port pads and controls
	logic [7:0] o_lat, o_dir, o_ext, o_out, o_oe, o_pu, o_lv, pcs, sv, cv, ctrl;
	logic [7:0] eo, eoe, epl, pl, lvl;
	logic rx1_line, dbg_o, pud_o, vts_o, vcu_o, s0r, t3i, e0, e1, xck, cap;
	logic [31:0] seed;
	int errors, checked;
	logic [7:0] exp_q [$];
	// Dataflow of the pad sample into the design keeps drives off the edge
	poior_top poior_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.bank_a_pad_in_i(plv[0]), .bank_b_pad_in_i(plv[1]), .bank_c_pad_in_i(plv[2]),
		.bank_a_pad_out_o(pout[0]), .bank_a_pad_oe_o(poe[0]), .bank_a_pullup_o(ppu[0]),
		.bank_b_pad_out_o(pout[1]), .bank_b_pad_oe_o(poe[1]), .bank_b_pullup_o(ppu[1]),
		.bank_c_pad_out_o(pout[2]), .bank_c_pad_oe_o(poe[2]), .bank_c_pullup_o(ppu[2]),
		.ovr_latch_i(o_lat), .ovr_direction_i(o_dir), .ovr_pad_in_i(o_lv),
		.ovr_pad_out_o(o_out), .ovr_pad_oe_o(o_oe), .ovr_pullup_o(o_pu),
		.serial0_transmitter_on_i(sv[0]), .serial0_receiver_on_i(sv[1]),
		.serial1_transmitter_on_i(sv[2]), .serial1_receiver_on_i(sv[3]),
		.serial0_transmit_line_i(sv[4]), .serial1_transmit_line_i(sv[5]),
		.timer1_compare_b_en_i(cv[0]), .timer1_compare_b_out_i(cv[4]),
		.timer1_compare_a_en_i(cv[1]), .timer1_compare_a_out_i(cv[5]),
		.timer2_compare_b_en_i(cv[2]), .timer2_compare_b_out_i(cv[6]),
		.timer2_compare_a_en_i(cv[3]), .timer2_compare_a_out_i(cv[7]),
		.pin_change_group3_enable_i(sv[6]), .pin_change_mask_i(o_ext),
		.external_irq_0_en_i(sv[7]), .external_irq_1_en_i(sv[1]),
		.serial0_receive_line_o(s0r), .serial1_receive_line_o(rx1_line), .timer1_capture_input_o(cap),
		.timer3_count_input_o(t3i), .serial1_external_clock_o(xck), .external_irq_0_o(e0), .external_irq_1_o(e1),
		.pin_change_source_o(pcs), .debug_port_disable_o(dbg_o), .global_pullup_disable_o(pud_o),
		.vector_table_select_o(vts_o), .vector_change_unlock_o(vcu_o));
	// One board model per port
	poior_board_model board_a_inst (.out_i(pout[0]), .oe_i(poe[0]), .pullup_i(ppu[0]), .ext_i(ext[0]), .level_o(plv[0]));
	poior_board_model board_b_inst (.out_i(pout[1]), .oe_i(poe[1]), .pullup_i(ppu[1]), .ext_i(ext[1]), .level_o(plv[1]));
	poior_board_model board_c_inst (.out_i(pout[2]), .oe_i(poe[2]), .pullup_i(ppu[2]), .ext_i(ext[2]), .level_o(plv[2]));
	poior_board_model board_o_inst (.out_i(o_out), .oe_i(o_oe), .pullup_i(o_pu), .ext_i(o_ext), .level_o(o_lv));
	// Verdict and end of run
	task automatic stop_test();
		if (errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Eight shift steps per byte so successive bytes are not simple shifts
	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// One bus cycle; a read notes its expected data for the watcher
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= w;
		rd_i <= ~w;
		addr_i <= a;
		wdata_i <= d;
		if (!w) exp_q.push_back(d);
	endtask
	// Strobes low for n edges
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			wr_i <= 1'b0;
			rd_i <= 1'b0;
		end
	endtask
	// Clock at 200 MHz
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// Read data stands only in the cycle after the strobe, zero otherwise
	always @(posedge clk_sys_i) begin
		if (rd_seen) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata", exp_v, rdata_o)
		end else if (!sys_rst_i) begin
			`CHK("rdata_idle", 8'h00, rdata_o)
		end
		rd_seen <= rd_i;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		seed = 32'h0001_403A;
		{sys_rst_i, ce_i, wr_i, rd_i, addr_i, wdata_i} = {2'h3, 18'h0_0000};
		{o_lat, o_dir, o_ext, sv, cv} = 40'h00_0000_0000;
		for (int b = 0; b < 3; b++) ext[b] = 8'h00;
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		for (int b = 0; b < 3; b++) begin
			bus(1'b0, 8'(3 * b + 1), 8'h00);
			bus(1'b0, 8'(3 * b + 2), 8'h00);
		end
		bus(1'b0, 8'h35, 8'h00);
		for (int it = 0; it < 16; it++) begin
			ctrl = rnd();
			bus(1'b1, 8'h35, ctrl);
			for (int b = 0; b < 3; b++) begin
				dir[b] = rnd();
				lat[b] = rnd();
				ext[b] <= rnd();
				bus(1'b1, 8'(3 * b + 1), dir[b]);
				bus(1'b1, 8'(3 * b + 2), lat[b]);
			end
			// Unmapped write must leave every register alone
			bus(1'b1, 8'h09, rnd());
			{o_lat, o_dir, o_ext} <= {rnd(), rnd(), rnd()};
			{sv, cv} <= {rnd(), rnd()};
			idle(6);
			`CHK("ctrl_bits", {ctrl[7], ctrl[4], ctrl[1:0]}, {dbg_o, pud_o, vts_o, vcu_o})
			for (int b = 0; b < 3; b++) begin
				pl = ~dir[b] & lat[b] & {8{~ctrl[4]}};
				`CHK("pad_oe", dir[b], poe[b])
				`CHK("pad_out", lat[b], pout[b])
				`CHK("pad_pullup", pl, ppu[b])
			end
			// Override port: register-derived values first, then each override
			eoe = o_dir;
			eo = o_lat;
			epl = ~o_dir & o_lat & {8{~ctrl[4]}};
			for (int k = 0; k < 4; k++) if (cv[k]) eo[4 + k] = cv[4 + k];
			if (sv[0]) {eoe[1], eo[1], epl[1]} = {1'b1, sv[4], 1'b0};
			if (sv[2]) {eoe[3], eo[3], epl[3]} = {1'b1, sv[5], 1'b0};
			if (sv[1]) {eoe[0], epl[0]} = {1'b0, o_lat[0] & ~ctrl[4]};
			if (sv[3]) {eoe[2], epl[2]} = {1'b0, o_lat[2] & ~ctrl[4]};
			`CHK("ovr_oe", eoe, o_oe)
			`CHK("ovr_out", eo, o_out)
			`CHK("ovr_pullup", epl, o_pu)
			lvl = (eoe & eo) | (~eoe & epl) | (~eoe & ~epl & o_ext);
			`CHK("ovr_pins", lvl, pcs)
			`CHK("rx1_line", lvl[2], rx1_line)
			`CHK("in_lines", {lvl[0], lvl[0], lvl[2], lvl[3], lvl[4], lvl[6]}, {s0r, t3i, e0, e1, xck, cap})
			bus(1'b0, 8'h35, ctrl & 8'hF3);
			bus(1'b0, 8'h09, 8'h00);
			for (int b = 0; b < 3; b++) begin
				pl = ~dir[b] & lat[b] & {8{~ctrl[4]}};
				lvl = (dir[b] & lat[b]) | (~dir[b] & pl) | (~dir[b] & ~pl & ext[b]);
				bus(1'b0, 8'(3 * b), lvl);
				bus(1'b0, 8'(3 * b + 1), dir[b]);
				bus(1'b0, 8'(3 * b + 2), lat[b]);
			end
			// Enable low only once read data is back to idle; a write then must not land
			idle(2);
			ce_i <= 1'b0;
			bus(1'b1, 8'h01, ~dir[0]);
			idle(1);
			ce_i <= 1'b1;
			bus(1'b0, 8'h01, dir[0]);
			// Write to the sample address flips the latch bits set in the data
			pl = rnd();
			lat[0] = lat[0] ^ pl;
			bus(1'b1, 8'h00, pl);
			bus(1'b0, 8'h02, lat[0]);
			// Direction write with the read straight after it
			dir[0] = ~dir[0];
			bus(1'b1, 8'h01, dir[0]);
			bus(1'b0, 8'h01, dir[0]);
		end
		idle(3);
		stop_test();
	end
endmodule
`default_nettype wire
